/* rtl/mdcd_decode.sv */
// Descriptor control word decoder with stream and control-stream outputs.
//
// The register addresses and register access over Wishbone were left to the implementer.
`timescale 1ns/1ps
`include "mdcd_defs.svh"
module mdcd_decode #(
	parameter int LEN_W = 23,
	parameter bit CS_BUILT = 1'b1
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [5:2] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic [31:0] stream_data_o,
	output logic [3:0] stream_keep_o,
	output logic stream_valid_o,
	output logic stream_last_o,
	input wire logic stream_ready_i,
	output logic [31:0] ctl_data_o,
	output logic ctl_valid_o,
	output logic ctl_last_o,
	input wire logic ctl_ready_i
);
	import mdcd_pkg::*;

	// Register map, one 32-bit word per index on the bus.
	// Index 0 holds the descriptor control word as software built it.
	// Indices 1 to 5 hold the user words, user_word_first first.
	// Index 6 is status: a write of bit 0 starts the descriptor.
	// Reading index 6 gives the state, the control-stream build flag and framing.
	// Index 7 counts every data beat accepted since reset.
	// All other indices read zero and ignore writes.
	//
	// The block stands in for the descriptor fetch of a full engine.
	// Software loads one descriptor through the bus and then starts it.
	// A start request is ignored while a descriptor is still in flight.
	// This keeps the length and flags stable for the whole buffer.
	// The memory side is outside this block, so data is a pattern.
	// Only the control word fields decide what reaches the stream.

	// Stored control word of the current descriptor.
	logic [31:0] ctrl_word_q;
	// Five user words sent ahead of a start buffer.
	logic [31:0] user_q [`MDCD_USER_WORDS];
	// Start request, waiting for the sequencer to pick it up.
	logic go_q;
	// Sequencer state: idle, user words, or data beats.
	mdcd_state_t state_q;
	// Bytes of the buffer not yet sent on the data stream.
	logic [LEN_W-1:0] remain_q;
	// Index of the user word now offered on the control stream.
	logic [2:0] user_idx_q;
	// End flag of the running descriptor, frozen at its start.
	logic eop_q;
	// High between a start buffer and the end buffer of a packet.
	logic in_packet_q;
	// Count of accepted data beats, readable by software.
	logic [31:0] beats_q;
	// Counting pattern that fills the data beats.
	logic [31:0] seq_q;
	// Length taken from the configured low bits of the control word.
	logic [LEN_W-1:0] len_w;
	// A bus request that has not been answered yet.
	logic req_w;
	// The sequencer takes a start request in this cycle.
	logic start_w;

	// Apply byte enables to one stored word.
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				r[b*8 +: 8] = nw[b*8 +: 8];
			end
		end
		return r;
	endfunction

	// Length uses only the configured low bits of the field.
	// Upper length bits beyond the width are ignored, which saves logic.
	// Software must keep its buffers within the configured width.
	assign len_w = ctrl_word_q[LEN_W-1:0];
	// A request is taken once; the ack cycle itself is not a new one.
	// Without this term a held request would be answered twice.
	assign req_w = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign start_w = go_q && (state_q == MDCD_IDLE);

	// Bus ack one cycle after request, dropped the next cycle.
	// A fixed single wait state keeps the slave simple to model.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= req_w;
		end
	end

	// Register writes; go self-clears when the engine picks it up.
	// A new go write in the pickup cycle wins over the clear.
	// Byte enables merge into the stored word, so partial writes work.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_word_q <= 32'h0;
			go_q <= 1'b0;
			for (int i = 0; i < `MDCD_USER_WORDS; i++) begin
				user_q[i] <= 32'h0;
			end
		end else begin
			if (start_w) begin
				go_q <= 1'b0;
			end
			if (req_w && wb_we_i) begin
				if (wb_adr_i == `MDCD_ADR_CTRL) begin
					ctrl_word_q <= merge(ctrl_word_q, wb_dat_i, wb_sel_i);
				end
				if (wb_adr_i == `MDCD_ADR_STAT && wb_sel_i[0] &&
					wb_dat_i[`MDCD_CTRL_GO_BIT] && state_q == MDCD_IDLE) begin
					go_q <= 1'b1;
				end
				for (int i = 0; i < `MDCD_USER_WORDS; i++) begin
					if (CS_BUILT && wb_adr_i == 4'(i + 1)) begin
						user_q[i] <= merge(user_q[i], wb_dat_i, wb_sel_i);
					end
				end
			end
		end
	end

	// Read data; unmapped offsets read zero. Status shows busy state.
	// Read data is registered and stands in the ack cycle.
	// Without the control stream the user words read zero.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_dat_o <= 32'h0;
		end else if (req_w) begin
			wb_dat_o <= 32'h0;
			if (wb_adr_i == `MDCD_ADR_CTRL) begin
				wb_dat_o <= ctrl_word_q;
			end else if (wb_adr_i == `MDCD_ADR_STAT) begin
				wb_dat_o <= {28'h0, in_packet_q, CS_BUILT, state_q};
			end else if (wb_adr_i == `MDCD_ADR_BEATS) begin
				wb_dat_o <= beats_q;
			end else if (CS_BUILT && wb_adr_i >= `MDCD_ADR_USER0 &&
				wb_adr_i < `MDCD_ADR_STAT) begin
				wb_dat_o <= user_q[3'(wb_adr_i - `MDCD_ADR_USER0)];
			end
		end
	end

	// Descriptor sequencer: user words of a start buffer, then the data.
	// The end flag is latched at start so later writes cannot cut a
	// packet short while its buffer is still being sent.
	// A zero-length buffer without user words goes straight back idle.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_q <= MDCD_IDLE;
			remain_q <= '0;
			user_idx_q <= 3'h0;
			eop_q <= 1'b0;
		end else begin
			unique case (state_q)
				MDCD_IDLE: begin
					if (start_w) begin
						remain_q <= len_w;
						eop_q <= ctrl_word_q[`MDCD_EOP_BIT];
						user_idx_q <= 3'h0;
						// Only start buffers carry user words out.
						if (CS_BUILT && ctrl_word_q[`MDCD_SOP_BIT]) begin
							state_q <= MDCD_USER;
						end else if (len_w != '0) begin
							state_q <= MDCD_DATA;
						end
					end
				end
				MDCD_USER: begin
					if (ctl_valid_o && ctl_ready_i) begin
						user_idx_q <= user_idx_q + 3'h1;
						if (ctl_last_o) begin
							state_q <= (remain_q != '0) ? MDCD_DATA : MDCD_IDLE;
						end
					end
				end
				MDCD_DATA: begin
					if (stream_valid_o && stream_ready_i) begin
						if (remain_q <= LEN_W'(`MDCD_BEAT_BYTES)) begin
							remain_q <= '0;
							state_q <= MDCD_IDLE;
						end else begin
							remain_q <= remain_q - LEN_W'(`MDCD_BEAT_BYTES);
						end
					end
				end
				default: state_q <= MDCD_IDLE;
			endcase
		end
	end

	// Packet framing: start flag opens, end flag closes the packet.
	// A buffer with neither flag leaves the framing as it was.
	// Software owns the flags; this block only follows them.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			in_packet_q <= 1'b0;
		end else if (start_w) begin
			if (ctrl_word_q[`MDCD_SOP_BIT]) begin
				in_packet_q <= !ctrl_word_q[`MDCD_EOP_BIT];
			end else if (ctrl_word_q[`MDCD_EOP_BIT]) begin
				in_packet_q <= 1'b0;
			end
		end
	end

	// Control stream output holds user words while offered.
	// The next word is looked up one step ahead so that the stream
	// can move one word per cycle when the sink is always ready.
	// Last marks the fifth word, after which the offer stops.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctl_valid_o <= 1'b0;
			ctl_last_o <= 1'b0;
			ctl_data_o <= 32'h0;
		end else if (state_q == MDCD_USER &&
			!(ctl_valid_o && ctl_ready_i && ctl_last_o)) begin
			if (!ctl_valid_o || ctl_ready_i) begin
				logic [2:0] nx;
				nx = ctl_valid_o ? user_idx_q + 3'h1 : user_idx_q;
				ctl_valid_o <= 1'b1;
				ctl_data_o <= user_q[nx];
				ctl_last_o <= (nx == 3'(`MDCD_USER_WORDS - 1));
			end
		end else begin
			ctl_valid_o <= 1'b0;
			ctl_last_o <= 1'b0;
		end
	end

	// Data beats carry a counting pattern in place of memory reads.
	// Each beat carries four bytes; the final one may carry fewer.
	// Keep shows the valid low bytes of that final beat.
	// Last is only raised on the final beat of an end buffer.
	// A stalled beat holds its data, keep and last unchanged.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			stream_valid_o <= 1'b0;
			stream_last_o <= 1'b0;
			stream_keep_o <= 4'h0;
			stream_data_o <= 32'h0;
			seq_q <= 32'h0;
			beats_q <= 32'h0;
		end else if (state_q == MDCD_DATA) begin
			logic [LEN_W-1:0] r;
			logic fire;
			fire = stream_valid_o && stream_ready_i;
			r = fire ? remain_q - LEN_W'(`MDCD_BEAT_BYTES) : remain_q;
			if (fire) begin
				beats_q <= beats_q + 32'h1;
				seq_q <= seq_q + 32'h1;
			end
			if (fire && remain_q <= LEN_W'(`MDCD_BEAT_BYTES)) begin
				stream_valid_o <= 1'b0;
				stream_last_o <= 1'b0;
			end else if (!stream_valid_o || fire) begin
				stream_valid_o <= 1'b1;
				stream_data_o <= fire ? seq_q + 32'h1 : seq_q;
				if (r <= LEN_W'(`MDCD_BEAT_BYTES)) begin
					stream_keep_o <= r == LEN_W'(1) ? 4'h1 :
						r == LEN_W'(2) ? 4'h3 : r == LEN_W'(3) ? 4'h7 : 4'hf;
					stream_last_o <= eop_q;
				end else begin
					stream_keep_o <= 4'hf;
					stream_last_o <= 1'b0;
				end
			end
		end else begin
			stream_valid_o <= 1'b0;
			stream_last_o <= 1'b0;
		end
	end
endmodule

/* rtl/mdcd_defs.svh */
// Constants for the memory_to_stream descriptor control decoder.
`ifndef MDCD_DEFS_SVH
`define MDCD_DEFS_SVH
`define MDCD_LEN_MSB 22
`define MDCD_LEN_MAX_W 23
`define MDCD_EOP_BIT 26
`define MDCD_SOP_BIT 27
`define MDCD_USER_WORDS 5
`define MDCD_BEAT_BYTES 4
`define MDCD_ADR_CTRL 4'h0
`define MDCD_ADR_USER0 4'h1
`define MDCD_ADR_STAT 4'h6
`define MDCD_ADR_BEATS 4'h7
`define MDCD_CTRL_GO_BIT 0
`define MDCD_CTRL_CS_BIT 1
`endif

/* rtl/mdcd_pkg.sv */
// Types for the memory_to_stream descriptor control decoder.
package mdcd_pkg;
	typedef enum logic [1:0] {
		MDCD_IDLE = 2'b00,
		MDCD_USER = 2'b01,
		MDCD_DATA = 2'b11
	} mdcd_state_t;
endpackage

/* testbench/mdcd_props.sv */
// Port checks for the descriptor decoder.
`timescale 1ns/1ps
module mdcd_props #(
	parameter int LEN_W = 23,
	parameter bit CS_BUILT = 1'b1
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o,
	input wire logic [31:0] stream_data_o,
	input wire logic [3:0] stream_keep_o,
	input wire logic stream_valid_o,
	input wire logic stream_last_o,
	input wire logic stream_ready_i,
	input wire logic [31:0] ctl_data_o,
	input wire logic ctl_valid_o,
	input wire logic ctl_last_o,
	input wire logic ctl_ready_i
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// A request taken, and the one-cycle answer it must earn.
	sequence s_req;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence s_ack;
		wb_ack_o ##1 !wb_ack_o;
	endsequence
	a_ack_answer: assert property (s_req |=> s_ack)
		else $error("ack not one cycle after request");
	a_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_stb_i))
		else $error("ack without request");
	a_data_hold: assert property (stream_valid_o && !stream_ready_i |=>
		stream_valid_o && $stable(stream_data_o))
		else $error("stream beat dropped in stall");
	a_keep_code: assert property (stream_valid_o |->
		stream_keep_o inside {4'h1, 4'h3, 4'h7, 4'hf})
		else $error("bad keep");
	a_last_valid: assert property (stream_last_o |-> stream_valid_o)
		else $error("last without valid");
	a_ctl_hold: assert property (ctl_valid_o && !ctl_ready_i |=>
		ctl_valid_o && $stable(ctl_data_o))
		else $error("control word dropped in stall");
	a_ctl_last: assert property (ctl_last_o |-> ctl_valid_o)
		else $error("control last without valid");
	a_no_ctl: assert property (!CS_BUILT |-> !ctl_valid_o)
		else $error("control stream used when absent");
endmodule
bind mdcd_decode mdcd_props #(.LEN_W(LEN_W), .CS_BUILT(CS_BUILT)) u_props (.*);

/* testbench/mdcd_sink.sv */
// Stream peripheral model taking data and control words.
`timescale 1ns/1ps
module mdcd_sink (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic slow_i,
	output logic s_ready_o,
	output logic c_ready_o
);
	logic ph_q;
	// Slow mode stalls on alternate cycles so holding is exercised.
	always_ff @(posedge clk_i) begin
		if (rst_i) ph_q <= 1'b0;
		else ph_q <= !ph_q;
	end
	assign s_ready_o = !slow_i || ph_q;
	assign c_ready_o = !slow_i || !ph_q;
endmodule

/* testbench/testbench.sv */
// Self-checking bench for the descriptor decoder.
`timescale 1ns/1ps
module testbench;
	logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, slow;
	logic [5:2] wb_adr_i;
	logic [3:0] wb_sel_i, stream_keep_o, nb, nc, nl, kl;
	logic [31:0] wb_dat_i, wb_dat_o, stream_data_o, ctl_data_o, cw, d;
	logic stream_valid_o, stream_last_o, stream_ready_i;
	logic ctl_valid_o, ctl_last_o, ctl_ready_i;
	int err_total = 0, compares = 0, cyc_n = 0;
	// Control word per row, then beats, control words, lasts, final keep.
	logic [31:0] r_ctl [6] = '{32'h0c000008, 32'h08000005, 32'h04000003,
		32'h00000102, 32'h00000000, 32'h04000106};
	logic [15:0] r_exp [6] = '{16'h251f, 16'h2501, 16'h1017, 16'h1003,
		16'h0000, 16'h2013};
	mdcd_decode #(.LEN_W(8), .CS_BUILT(1'b1)) u_dut (.*);
	mdcd_sink u_sink (.clk_i(clk_i), .rst_i(rst_i), .slow_i(slow),
		.s_ready_o(stream_ready_i), .c_ready_o(ctl_ready_i));
	always #25 clk_i = !clk_i;
	task wrap_up;
		$display("compares %0d errors %0d", compares, err_total);
		if (err_total == 0 && compares > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task automatic check(input string n, input logic [31:0] s, e);
		compares++;
		if (s !== e) begin
			err_total++;
			$display("ERROR %s exp %h got %h", n, e, s);
		end
	endtask
	// One classic cycle; held until ack is sampled high.
	task automatic bus(input logic w, input logic [3:0] a,
		input logic [31:0] v);
		wb_adr_i <= a;
		wb_dat_i <= v;
		wb_we_i <= w;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		do @(posedge clk_i); while (wb_ack_o !== 1'b1);
		d = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge clk_i);
	endtask
	// Run one descriptor: go twice, the second lands while busy unless the buffer is empty.
	task automatic run(input logic [31:0] c, input logic [15:0] e);
		nb = 0;
		nc = 0;
		nl = 0;
		kl = 0;
		bus(1, 4'h0, c);
		bus(1, 4'h6, 32'h1);
		bus(1, 4'h6, 32'h1);
		do bus(0, 4'h6, 0); while (d[1:0] !== 2'b00);
		check("packet", {nb, nc, nl, kl}, e);
	endtask
	// Count accepted beats; also cuts a hang short.
	always @(posedge clk_i) begin
		if (stream_valid_o && stream_ready_i) begin
			nb++;
			nl += stream_last_o;
			kl = stream_keep_o;
		end
		if (ctl_valid_o && ctl_ready_i) begin
			nc++;
			cw = ctl_data_o;
		end
		if (++cyc_n == 20000) begin
			err_total++;
			wrap_up;
		end
	end
	initial begin
		{clk_i, wb_cyc_i, wb_stb_i, wb_we_i, slow} = 0;
		{wb_adr_i, wb_dat_i} = 0;
		wb_sel_i = 4'hf;
		rst_i = 1;
		repeat (6) @(posedge clk_i);
		rst_i <= 0;
		@(posedge clk_i);
		bus(0, 4'h6, 0);
		check("status", d, 32'h4);
		for (int j = 1; j < 6; j++) bus(1, j[3:0], 32'ha0 + j);
		for (int i = 0; i < 6; i++) begin
			slow <= i[0];
			run(r_ctl[i], r_exp[i]);
		end
		check("user", cw, 32'ha5);
		bus(0, 4'h7, 0);
		check("beats", d, 32'h8);
		bus(0, 4'h0, 0);
		check("ctrl", d, 32'h04000106);
		bus(0, 4'hc, 0);
		check("unmapped", d, 32'h0);
		// Reset in the middle of a long start buffer clears everything.
		bus(1, 4'h0, 32'h080000ff);
		bus(1, 4'h6, 32'h1);
		repeat (20) @(posedge clk_i);
		rst_i <= 1;
		repeat (2) @(posedge clk_i);
		rst_i <= 0;
		@(posedge clk_i);
		check("rst valid", {stream_valid_o, ctl_valid_o, wb_ack_o}, 0);
		bus(0, 4'h6, 0);
		check("rst status", d, 32'h4);
		bus(0, 4'h7, 0);
		check("rst beats", d, 32'h0);
		wrap_up;
	end
endmodule
